// file: shared/drc_pkg.sv
/*
 * Shared constants and types of the drive run command logic: register map,
 * field layout, reset values, terminal function codes, timing counts.
 * Assumes a single 100 MHz clock and an AHB-Lite register port.
 */
`default_nettype none

package drc_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FILTER_TIME_NS = 1000000;                      // 1 ms input filter
	localparam int FILTER_CYCLES  = FILTER_TIME_NS / CLK_PERIOD_NS;
	localparam int MS_TICK_NS     = 1000000;                      // 1 ms time base
	localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int MS_PER_S       = 1000;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL        = 8'h00;
	localparam logic [7:0] ADDR_STOP_METHOD = 8'h04;
	localparam logic [7:0] ADDR_FSEL_LO     = 8'h08;
	localparam logic [7:0] ADDR_FSEL_HI     = 8'h0c;
	localparam logic [7:0] ADDR_STATUS      = 8'h10;

	// ==========================================================
	// Control fields and settings
	localparam int         CTRL_SHUTOFF_LSB = 0;
	localparam int         CTRL_COMM_STOP   = 4;
	localparam logic [2:0] SHUTOFF_NO       = 3'h0;
	localparam logic [2:0] SHUTOFF_NC       = 3'h2;
	localparam logic [2:0] SHUTOFF_MIXED    = 3'h4;
	localparam logic [2:0] SHUTOFF_RESET    = SHUTOFF_NO;

	localparam logic [13:0] STOP_RAMP_2W    = 14'h270f;           // 9999
	localparam logic [13:0] STOP_RAMP_SD    = 14'h22b8;           // 8888
	localparam logic [13:0] COAST_2W_MAX    = 14'h0064;           // 100 s
	localparam logic [13:0] COAST_SD_MIN    = 14'h03e8;           // 1000: 0 s delay
	localparam logic [13:0] COAST_SD_MAX    = 14'h044c;           // 1100: 100 s delay
	localparam logic [13:0] STOP_RESET      = STOP_RAMP_2W;

	// ==========================================================
	// Terminal function codes and selection reset values
	localparam int         NUM_TERMS     = 7;
	localparam logic [7:0] FN_SECOND_SET = 8'h03;
	localparam logic [7:0] FN_OUT_STOP   = 8'h18;
	localparam logic [7:0] FN_FWD_START  = 8'h3c;
	localparam logic [7:0] FN_REV_START  = 8'h3d;
	localparam logic [7:0] FN_NONE       = 8'hff;
	localparam logic [31:0] FSEL_LO_RESET = 32'h03183d3c;         // t3 sel, t2 stop, t1 rev, t0 fwd
	localparam logic [31:0] FSEL_HI_RESET = 32'h00ffffff;         // t6..t4 no function

	// ==========================================================
	// Status fields
	localparam int ST_OUT_ON    = 0;
	localparam int ST_RUN       = 1;
	localparam int ST_REVERSE   = 2;
	localparam int ST_SECOND    = 3;
	localparam int ST_COAST     = 4;
	localparam int ST_DECEL     = 5;
	localparam int ST_ALLOWED   = 6;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_TERM_LSB  = 16;
	localparam int ST_CONV      = 23;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		DRC_IDLE  = 3'b000,
		DRC_RUN   = 3'b001,
		DRC_DECEL = 3'b011,
		DRC_DELAY = 3'b010
	} drc_state_t;

	typedef struct packed {
		logic start;
		logic reverse;
	} drc_cmd_t;

	typedef struct packed {
		logic       start_dir;
		logic       coast;
		logic [6:0] coast_s;
	} drc_mode_t;

endpackage

`default_nettype wire

// file: core/drc_input_filter.sv
/*
 * One input line: two-flop synchroniser followed by a stability filter.
 * Assumes the pin is asynchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none

module drc_input_filter #(
	parameter int FILTER_CYCLES = 100000
) (
	input  wire logic hclk,      // System clock
	input  wire logic hresetn,   // Async reset, active low
	input  wire logic pin_in,    // Raw pin level
	output var  logic level_q    // Filtered level
);
	localparam int CW = $clog2(FILTER_CYCLES + 1);

	logic          meta_q;
	logic          sync_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	// A change is taken only after it has held for the whole filter time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else if (sync_q == level_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(FILTER_CYCLES - 1)) begin
			cnt_q   <= '0;
			level_q <= sync_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule

`default_nettype wire

// file: core/drc_coast_timer.sv
/*
 * Whole-second delay timer with its own millisecond divider.
 * Assumes arm is a one-cycle pulse; cancel stops a running count.
 */
`timescale 1ns/1ps
`default_nettype none

module drc_coast_timer #(
	parameter int TICK_CYCLES = 100000
) (
	input  wire logic       hclk,      // System clock
	input  wire logic       hresetn,   // Async reset, active low
	input  wire logic       arm,       // Load and start, pulse
	input  wire logic       cancel,    // Abandon count, pulse
	input  wire logic [6:0] seconds,   // Delay in seconds
	output var  logic       expired_q  // Delay over, pulse
);
	localparam int DW = $clog2(TICK_CYCLES);

	logic [DW-1:0] div_q;
	logic [9:0]    ms_q;
	logic [6:0]    sec_q;
	logic          busy_q;
	logic          tick;

	assign tick = (div_q == DW'(TICK_CYCLES - 1));

	// Divider restarts on arm so the delay is never short by a partial tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= '0;
		end else if (arm || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q    <= 1'b0;
			ms_q      <= '0;
			sec_q     <= '0;
			expired_q <= 1'b0;
		end else begin
			expired_q <= 1'b0;
			if (arm) begin
				busy_q <= 1'b1;
				ms_q   <= '0;
				sec_q  <= seconds;
			end else if (cancel) begin
				busy_q <= 1'b0;
			end else if (busy_q && sec_q == 7'h00) begin
				busy_q    <= 1'b0;
				expired_q <= 1'b1;
			end else if (busy_q && tick) begin
				if (ms_q == 10'(drc_pkg::MS_PER_S - 1)) begin
					ms_q  <= '0;
					sec_q <= sec_q - 1'b1;
				end else begin
					ms_q <= ms_q + 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// file: core/drc_top.sv
/*
 * Drive run command logic: output-stop combination, start decode,
 * stop method, second parameter set select, AHB-Lite register slave.
 * Assumes terminal pins are asynchronous and ramp_done comes from the
 * frequency ramp on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Output stop during running cuts drive output at once, no ramp.
// - Active output stop blocks any start; start commands are ignored.
// - Start release ramps down; output stop instead lets the motor coast.
// - Shutoff setting 2 reads the stop terminal as normally closed.
// - Setting 4: terminal stop normally closed, communication stop normally open.
// - Operation enabled only for the listed stop combinations per setting.
// - Output stop acts in panel, terminal and network modes alike.
// - Stop defaults to its dedicated terminal; code 24 maps it anywhere.
// - Code 3 on any terminal makes it the second-set select.
// - Second-set select swaps all first parameters for second ones at once.
// - Stop selection defaults 9999: forward, reverse inputs, ramp on release.
// - Setting 8888: start plus direction inputs, ramp down on release.
// - Two-wire: exactly one input runs that way; none or both ramp down.
// - Forward start only on first input, reverse only on second input.
// - Stop and converter enable answer within 2 ms, others within 20 ms.
// - Stop or second-set code on several terminals is the OR of those terminals.
// - Start-direction modes: start alone forward, both reverse, no start stops.
module drc_top #(
	parameter int FILTER_CYCLES = drc_pkg::FILTER_CYCLES,   // Input filter length
	parameter int TICK_CYCLES   = drc_pkg::MS_TICK_CYCLES   // Millisecond divider
) (
	input  wire logic        hclk,                 // System clock, 100 MHz
	input  wire logic        hresetn,              // Async reset, active low
	input  wire logic        hsel,                 // AHB slave select
	input  wire logic [31:0] haddr,                // AHB address
	input  wire logic [1:0]  htrans,               // AHB transfer type
	input  wire logic        hwrite,               // AHB write
	input  wire logic [2:0]  hsize,                // AHB size, words only
	input  wire logic [31:0] hwdata,               // AHB write data
	input  wire logic        hready,               // AHB bus ready
	output var  logic        hreadyout,            // AHB slave ready
	output var  logic [31:0] hrdata,               // AHB read data
	output var  logic        hresp,                // AHB response, always OKAY
	input  wire logic [6:0]  term_in,              // Input terminals, t0 first, t1 second
	input  wire logic        converter_run_enable, // Converter enable pin
	input  wire logic        ramp_done,            // Deceleration finished
	output var  logic        drive_output_on_q,    // Power stage enabled
	output var  logic        run_q,                // Run at set speed
	output var  logic        reverse_q,            // Reverse direction
	output var  logic        decel_q,              // Ramping down
	output var  logic        second_set_select_q   // Second parameter set in use
);

	// ==========================================================
	// Input conditioning
	logic [6:0] term_f;
	logic       conv_f;

	for (genvar t = 0; t < drc_pkg::NUM_TERMS; t++) begin : g_term
		drc_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
			.hclk    (hclk),
			.hresetn (hresetn),
			.pin_in  (term_in[t]),
			.level_q (term_f[t])
		);
	end

	drc_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_conv_filt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (converter_run_enable),
		.level_q (conv_f)
	);

	// ==========================================================
	// Registers
	logic [2:0]  shutoff_logic_setting_q;
	logic        comm_stop_q;
	logic [13:0] stop_method_setting_q;
	logic [7:0]  fsel_q [drc_pkg::NUM_TERMS];
	logic        pend_q;
	logic        pend_wr_q;
	logic [7:0]  pend_addr_q;
	logic        coast_flag_q;

	drc_pkg::drc_state_t state_q;
	drc_pkg::drc_state_t state_d;
	logic [31:0]         status;

	// One wait state per transfer keeps hrdata straight from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q      <= 1'b0;
			pend_wr_q   <= 1'b0;
			pend_addr_q <= '0;
			hreadyout   <= 1'b1;
		end else if (hsel && hready && htrans[1]) begin
			pend_q      <= 1'b1;
			pend_wr_q   <= hwrite;
			pend_addr_q <= haddr[7:0];
			hreadyout   <= 1'b0;
		end else begin
			pend_q    <= 1'b0;
			hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
			hresp  <= 1'b0;
		end else if (pend_q && !pend_wr_q) begin
			case (pend_addr_q)
				drc_pkg::ADDR_CTRL: begin
					hrdata <= 32'h0 | (32'(shutoff_logic_setting_q) << drc_pkg::CTRL_SHUTOFF_LSB)
					        | (32'(comm_stop_q) << drc_pkg::CTRL_COMM_STOP);
				end
				drc_pkg::ADDR_STOP_METHOD: hrdata <= {18'h0, stop_method_setting_q};
				drc_pkg::ADDR_FSEL_LO:     hrdata <= {fsel_q[3], fsel_q[2], fsel_q[1], fsel_q[0]};
				drc_pkg::ADDR_FSEL_HI:     hrdata <= {8'h00, fsel_q[6], fsel_q[5], fsel_q[4]};
				drc_pkg::ADDR_STATUS:      hrdata <= status;
				default:                   hrdata <= '0;
			endcase
		end
	end

	// Unsupported shutoff settings are dropped so the decode never sees them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shutoff_logic_setting_q <= drc_pkg::SHUTOFF_RESET;
			comm_stop_q             <= 1'b0;
		end else if (pend_q && pend_wr_q && pend_addr_q == drc_pkg::ADDR_CTRL) begin
			comm_stop_q <= hwdata[drc_pkg::CTRL_COMM_STOP];
			if (hwdata[drc_pkg::CTRL_SHUTOFF_LSB +: 3] == drc_pkg::SHUTOFF_NO
			    || hwdata[drc_pkg::CTRL_SHUTOFF_LSB +: 3] == drc_pkg::SHUTOFF_NC
			    || hwdata[drc_pkg::CTRL_SHUTOFF_LSB +: 3] == drc_pkg::SHUTOFF_MIXED) begin
				shutoff_logic_setting_q <= hwdata[drc_pkg::CTRL_SHUTOFF_LSB +: 3];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_method_setting_q <= drc_pkg::STOP_RESET;
		end else if (pend_q && pend_wr_q && pend_addr_q == drc_pkg::ADDR_STOP_METHOD) begin
			stop_method_setting_q <= hwdata[13:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				fsel_q[i] <= drc_pkg::FSEL_LO_RESET[8*i +: 8];
			end
			for (int i = 4; i < drc_pkg::NUM_TERMS; i++) begin
				fsel_q[i] <= drc_pkg::FSEL_HI_RESET[8*(i-4) +: 8];
			end
		end else if (pend_q && pend_wr_q && pend_addr_q == drc_pkg::ADDR_FSEL_LO) begin
			for (int i = 0; i < 4; i++) begin
				fsel_q[i] <= hwdata[8*i +: 8];
			end
		end else if (pend_q && pend_wr_q && pend_addr_q == drc_pkg::ADDR_FSEL_HI) begin
			for (int i = 4; i < drc_pkg::NUM_TERMS; i++) begin
				fsel_q[i] <= hwdata[8*(i-4) +: 8];
			end
		end
	end

	// ==========================================================
	// Terminal function map
	logic [6:0] stop_hit;
	logic [6:0] second_hit;
	logic       output_stop_input;
	logic       forward_start_input;
	logic       reverse_start_input;

	always_comb begin
		for (int i = 0; i < drc_pkg::NUM_TERMS; i++) begin
			stop_hit[i]   = term_f[i] && fsel_q[i] == drc_pkg::FN_OUT_STOP;
			second_hit[i] = term_f[i] && fsel_q[i] == drc_pkg::FN_SECOND_SET;
		end
	end

	assign output_stop_input   = |stop_hit;
	assign forward_start_input = term_f[0] && fsel_q[0] == drc_pkg::FN_FWD_START;
	assign reverse_start_input = term_f[1] && fsel_q[1] == drc_pkg::FN_REV_START;

	// ==========================================================
	// Output-stop combination
	logic op_enabled;
	logic run_allowed;

	// Same decode for every command source, nothing here looks at the mode
	always_comb begin
		case (shutoff_logic_setting_q)
			drc_pkg::SHUTOFF_NC:    op_enabled = output_stop_input && comm_stop_q;
			drc_pkg::SHUTOFF_MIXED: op_enabled = output_stop_input && !comm_stop_q;
			default:                op_enabled = !output_stop_input && !comm_stop_q;
		endcase
	end

	assign run_allowed = op_enabled && conv_f;

	// ==========================================================
	// Stop method and start decode
	drc_pkg::drc_mode_t mode;
	drc_pkg::drc_cmd_t  cmd;

	always_comb begin
		mode.start_dir = 1'b0;
		mode.coast     = 1'b0;
		mode.coast_s   = '0;
		if (stop_method_setting_q <= drc_pkg::COAST_2W_MAX) begin
			mode.coast   = 1'b1;
			mode.coast_s = stop_method_setting_q[6:0];
		end else if (stop_method_setting_q >= drc_pkg::COAST_SD_MIN
		             && stop_method_setting_q <= drc_pkg::COAST_SD_MAX) begin
			mode.start_dir = 1'b1;
			mode.coast     = 1'b1;
			mode.coast_s   = 7'(stop_method_setting_q - drc_pkg::COAST_SD_MIN);
		end else if (stop_method_setting_q == drc_pkg::STOP_RAMP_SD) begin
			mode.start_dir = 1'b1;
		end
	end

	// Values outside every range fall back to the default ramp behaviour
	always_comb begin
		if (mode.start_dir) begin
			cmd.start   = forward_start_input;
			cmd.reverse = reverse_start_input;
		end else begin
			cmd.start   = forward_start_input ^ reverse_start_input;
			cmd.reverse = reverse_start_input;
		end
	end

	// ==========================================================
	// Run sequencer
	logic timer_arm;
	logic timer_cancel;
	logic timer_expired;
	logic coast_event;

	always_comb begin
		state_d = state_q;
		case (state_q)
			drc_pkg::DRC_IDLE: begin
				if (cmd.start && run_allowed) begin
					state_d = drc_pkg::DRC_RUN;
				end
			end
			drc_pkg::DRC_RUN: begin
				if (!run_allowed) begin
					state_d = drc_pkg::DRC_IDLE;
				end else if (!cmd.start) begin
					state_d = mode.coast ? drc_pkg::DRC_DELAY : drc_pkg::DRC_DECEL;
				end
			end
			drc_pkg::DRC_DECEL: begin
				if (!run_allowed || ramp_done) begin
					state_d = drc_pkg::DRC_IDLE;
				end else if (cmd.start) begin
					state_d = drc_pkg::DRC_RUN;
				end
			end
			drc_pkg::DRC_DELAY: begin
				if (!run_allowed || ramp_done || timer_expired) begin
					state_d = drc_pkg::DRC_IDLE;
				end else if (cmd.start) begin
					state_d = drc_pkg::DRC_RUN;
				end
			end
			default: state_d = drc_pkg::DRC_IDLE;
		endcase
	end

	assign timer_arm    = state_q == drc_pkg::DRC_RUN && state_d == drc_pkg::DRC_DELAY;
	assign timer_cancel = state_q == drc_pkg::DRC_DELAY && state_d != drc_pkg::DRC_DELAY;
	assign coast_event  = state_q != drc_pkg::DRC_IDLE && state_d == drc_pkg::DRC_IDLE && !ramp_done;

	drc_coast_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.arm       (timer_arm),
		.cancel    (timer_cancel),
		.seconds   (mode.coast_s),
		.expired_q (timer_expired)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= drc_pkg::DRC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Output cut the same cycle the state leaves, not after a ramp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_output_on_q <= 1'b0;
			run_q             <= 1'b0;
			decel_q           <= 1'b0;
		end else begin
			drive_output_on_q <= run_allowed && state_d != drc_pkg::DRC_IDLE;
			run_q             <= state_d == drc_pkg::DRC_RUN;
			decel_q           <= state_d == drc_pkg::DRC_DECEL || state_d == drc_pkg::DRC_DELAY;
		end
	end

	// Direction follows the inputs only while running; held through the ramp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reverse_q <= 1'b0;
		end else if (state_d == drc_pkg::DRC_RUN) begin
			reverse_q <= cmd.reverse;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coast_flag_q <= 1'b0;
		end else if (coast_event) begin
			coast_flag_q <= 1'b1;
		end else if (state_d == drc_pkg::DRC_RUN) begin
			coast_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Second parameter set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			second_set_select_q <= 1'b0;
		end else begin
			second_set_select_q <= |second_hit;
		end
	end

	// ==========================================================
	// Status word
	always_comb begin
		status                                   = '0;
		status[drc_pkg::ST_OUT_ON]               = drive_output_on_q;
		status[drc_pkg::ST_RUN]                  = run_q;
		status[drc_pkg::ST_REVERSE]              = reverse_q;
		status[drc_pkg::ST_SECOND]               = second_set_select_q;
		status[drc_pkg::ST_COAST]                = coast_flag_q;
		status[drc_pkg::ST_DECEL]                = decel_q;
		status[drc_pkg::ST_ALLOWED]              = run_allowed;
		status[drc_pkg::ST_STATE_LSB +: 3]       = state_q;
		status[drc_pkg::ST_TERM_LSB +: 7]        = term_f;
		status[drc_pkg::ST_CONV]                 = conv_f;
	end

endmodule

`default_nettype wire

// file: testbench/drc_monitor.sv
/* Port checker for drc_top: bus handshake and drive output relations.
   Assumes hready is fed back from hreadyout and t3 keeps its select code. */
`timescale 1ns/1ps
`default_nettype none
module drc_monitor #(
	parameter int FILTER_CYCLES = 4,   // Input filter length
	parameter int TICK_CYCLES   = 10   // Millisecond divider
) (
	input wire logic        hclk,                 // Clock
	input wire logic        hresetn,              // Reset, active low
	input wire logic        hsel,                 // Select
	input wire logic [31:0] haddr,                // Address
	input wire logic [1:0]  htrans,               // Transfer type
	input wire logic        hwrite,               // Write
	input wire logic [2:0]  hsize,                // Size
	input wire logic [31:0] hwdata,               // Write data
	input wire logic        hready,               // Bus ready
	input wire logic        hreadyout,            // Slave ready
	input wire logic [31:0] hrdata,               // Read data
	input wire logic        hresp,                // Response
	input wire logic [6:0]  term_in,              // Terminals
	input wire logic        converter_run_enable, // Converter enable
	input wire logic        ramp_done,            // Ramp finished
	input wire logic        drive_output_on_q,    // Output on
	input wire logic        run_q,                // Running
	input wire logic        reverse_q,            // Reverse
	input wire logic        decel_q,              // Ramping down
	input wire logic        second_set_select_q   // Second set
);
	// Filter plus sync plus output stage, with margin
	localparam int LAT = FILTER_CYCLES + 8;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========
	// Sequences
	sequence s_taken; hsel && hready && htrans[1]; endsequence
	sequence s_wait; !hreadyout ##1 hreadyout; endsequence
	// ==========
	// Assertions
	a_ready_wait: assert property (s_taken |=> s_wait) else $error("wait state pattern wrong");
	a_ready_short: assert property (!hreadyout |=> hreadyout) else $error("ready low too long");
	a_resp_okay: assert property (!hresp) else $error("response not okay");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
	a_run_out_on: assert property (run_q |-> drive_output_on_q) else $error("running with output off");
	a_decel_no_run: assert property (!(decel_q && run_q)) else $error("ramp and run together");
	a_conv_cuts_out: assert property ((!converter_run_enable)[*8] |-> ##[0:LAT] !drive_output_on_q)
		else $error("converter disable ignored");
	a_second_sel: assert property (term_in[3][*8] |-> ##[0:LAT] second_set_select_q)
		else $error("second set not taken");
endmodule
bind drc_top drc_monitor #(.FILTER_CYCLES(FILTER_CYCLES), .TICK_CYCLES(TICK_CYCLES)) i_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .term_in(term_in), .converter_run_enable(converter_run_enable),
	.ramp_done(ramp_done), .drive_output_on_q(drive_output_on_q), .run_q(run_q),
	.reverse_q(reverse_q), .decel_q(decel_q), .second_set_select_q(second_set_select_q));
`default_nettype wire

// file: testbench/drc_term_model.sv
/* Terminal and converter pin model: contacts switch off the clock grid.
   Assumes the bench gives wanted levels; skew keeps pins asynchronous. */
`timescale 1ns/1ps
`default_nettype none
module drc_term_model #(
	parameter real SKEW = 3.3   // Contact delay, ns
) (
	input  wire logic [6:0] want,                 // Wanted terminal levels
	input  wire logic       conv_want,            // Wanted converter level
	output wire logic [6:0] term_in,              // Terminal pins
	output wire logic       converter_run_enable  // Converter pin
);
	// Continuous delay also carries the time-zero levels, which an event wait could miss
	assign #SKEW term_in              = want;
	assign #SKEW converter_run_enable = conv_want;
endmodule
`default_nettype wire

// file: testbench/drc_tb_top.sv
/* Self-checking bench of drc_top: bus master tasks, pin model, status checks.
   Assumes short filter and tick counts set here. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module drc_tb_top;
	localparam int FLT = 4;
	localparam int SETTLE = FLT + 10;
	localparam logic [7:0] ST = drc_pkg::ADDR_STATUS;
	typedef struct packed {logic [31:0] v; logic [31:0] m; logic p;} drc_note_t;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ramp_done, conv, rd_ph;
	logic        out_on, run, rev, dec, sec;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  want, term_in;
	logic        conv_pin;
	int          miscompares, cmp_count;
	drc_note_t   notes[$], n;
	logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
	logic [31:0] rv[5] = '{32'h0, 32'h270f, 32'h03183d3c, 32'h00ffffff, 32'h0};
	drc_top #(.FILTER_CYCLES(FLT), .TICK_CYCLES(10)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .term_in(term_in), .converter_run_enable(conv_pin),
		.ramp_done(ramp_done), .drive_output_on_q(out_on), .run_q(run), .reverse_q(rev), .decel_q(dec),
		.second_set_select_q(sec));
	drc_term_model i_pins (.want(want), .conv_want(conv), .term_in(term_in), .converter_run_enable(conv_pin));
	initial begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========
	// Bus master: address phase held until ready, then data phase until ready
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge hclk); k++; end while (!hreadyout && k < 50);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do begin @(posedge hclk); k++; end while (!hreadyout && k < 50);
		rd_ph <= 0;
		if (k >= 50) begin miscompares++; complete_run(); end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		notes.push_back('{v & m, m, a == ST});
		xfer(0, a, 32'h0);
	endtask
	// Unused terminal t6 gets random noise; it has no function
	task step(input logic [6:0] p, input logic [31:0] m, input logic [31:0] v);
		seed = lfsr(seed);
		want <= {seed[0], p[5:0]};
		repeat (SETTLE) @(posedge hclk);
		rd(ST, m, v);
	endtask
	always @(posedge hclk) if (rd_ph && hreadyout) begin
		n = notes.pop_front();
		`CHK(hrdata & n.m, n.v)
		// Status reads also hold the output pins against the same expectation
		if (n.p) `CHK({26'h0, dec, 1'b0, sec, rev, run, out_on} & n.m, n.v)
	end
	// ==========
	// Main sequence
	initial begin
		hresetn = 0; hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0; hsize = 3'h2;
		want = 0; conv = 1; ramp_done = 0; rd_ph = 0; seed = 32'd82430; miscompares = 0; cmp_count = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		for (int i = 0; i < 5; i++) rd(ra[i], '1, rv[i]);
		xfer(1, 8'h14, seed);
		rd(8'h14, '1, 32'h0);
		xfer(1, 8'h00, 32'h13);
		rd(8'h00, 32'h17, 32'h10);
		xfer(1, 8'h00, 32'h0);
		step(7'h01, 32'h27, 32'h03);
		step(7'h03, 32'h27, 32'h21);
		ramp_done <= 1;
		step(7'h00, 32'h27, 32'h00);
		foreach (rv[i]) if (i < 2) begin
			xfer(1, 8'h04, i ? 32'd1001 : 32'd1);
			ramp_done <= 0;
			step(7'h01, 32'h27, 32'h03);
			step(7'h00, 32'h23, 32'h21);
			repeat (9000) @(posedge hclk);
			rd(ST, 32'h21, 32'h21);
			repeat (1100) @(posedge hclk);
			rd(ST, 32'h03, 32'h00);
			ramp_done <= 1;
		end
		xfer(1, 8'h04, 32'h22b8);
		step(7'h01, 32'h07, 32'h03);
		step(7'h03, 32'h07, 32'h07);
		step(7'h02, 32'h03, 32'h00);
		xfer(1, 8'h04, 32'h270f);
		for (int s = 0; s < 3; s++) for (int e = 0; e < 4; e++) begin
			xfer(1, 8'h00, {27'h0, e[1], 1'b0, 3'(2 * s)});
			step({4'h0, e[0], 2'h2}, 32'h03, ((s == 0 && e == 0) || (s == 1 && e == 3) || (s == 2 && e == 1)) ? 32'h3 : 32'h0);
		end
		xfer(1, 8'h00, 32'h0);
		xfer(1, 8'h0c, 32'h00ffff18);
		step(7'h12, 32'h03, 32'h00);
		step(7'h02, 32'h07, 32'h07);
		conv <= 0;
		step(7'h02, 32'h01, 32'h00);
		conv <= 1;
		step(7'h0a, 32'h0b, 32'h0b);
		complete_run();
	end
endmodule
`default_nettype wire
